//--- fpnp_map.vh
`ifndef FPNP_MAP_VH
`define FPNP_MAP_VH
// single precision field layout
`define FPNP_W 32
`define FPNP_SIGN_BIT 31
`define FPNP_EXP_HI 30
`define FPNP_EXP_LO 23
`define FPNP_FRAC_HI 22
`define FPNP_FRAC_LO 0
`define FPNP_QUIET_BIT 22
`define FPNP_EXP_MAX 8'hff
`define FPNP_EXP_ZERO 8'h00
// default indefinite encoding: value is a parameter default, arbitrary choice
`define FPNP_INDEF_DEFAULT 32'hffc00000
// operation codes
`define FPNP_OP_ADD 3'h0
`define FPNP_OP_SUB 3'h1
`define FPNP_OP_MUL 3'h2
`define FPNP_OP_CMP 3'h3
`define FPNP_OP_UNARY 3'h4
`define FPNP_OP_CMPS 3'h5
// compare result encoding
`define FPNP_CMP_LT 2'h0
`define FPNP_CMP_EQ 2'h1
`define FPNP_CMP_GT 2'h2
`define FPNP_CMP_UN 2'h3
// class codes
`define FPNP_CL_ZERO 3'h0
`define FPNP_CL_DENORM 3'h1
`define FPNP_CL_NORM 3'h2
`define FPNP_CL_INF 3'h3
`define FPNP_CL_QUIET_NOT_A_NUMBER 3'h4
`define FPNP_CL_SIGNALING_NOT_A_NUMBER 3'h5
// pipeline latency from request to result, in cycles
`define FPNP_LATENCY 2
`endif

//--- fpnp_special_unit.v
`timescale 1ns/1ps
`include "fpnp_map.vh"
// How it works
// - max exponent with zero fraction is infinity; sign picks plus or minus.
// - compares order minus infinity below and plus infinity above finites.
// - infinity arithmetic is exact; only invalid uses raise invalid.
// - biased exponent at or above format maximum flags overflow; result signed infinity.
// - max exponent with nonzero fraction is not-a-number, sign ignored.
// - top fraction bit one means quiet, zero means signaling.
// - quiet values pass silently; signaling values raise invalid.
// - no signaling value is ever produced as a result.
// - signaling source with invalid unmasked: exception, no destination write.
// - quiet source on quiet-faulting op, unmasked: exception, no write.
// - masked: signaling result quieted by setting top fraction bit.
// - masked: sticky invalid flag set for signaling or faulting quiet source.
// - masked invalid with no NaN source yields the default indefinite.
// - signaling plus quiet: stack gives quiet; vector gives first, quieted.
// - two signaling: stack gives larger significand; vector gives first; quieted.
// - two quiet: stack gives larger significand; vector gives first unchanged.
// - signaling with ordinary operand gives that value quieted.
// - quiet with ordinary operand passes through unchanged.
// - single operand: signaling is quieted, quiet passes unchanged.
// - one reserved quiet encoding is the default indefinite value.
// - zero exponent with nonzero fraction classifies as denormal.
module fpnp_special_unit #(
  parameter [31:0] INDEF_VALUE = `FPNP_INDEF_DEFAULT
) (
  input wire clk,
  input wire rst,
  input wire reqValid,
  input wire [2:0] reqOp,
  input wire [31:0] srcA,
  input wire [31:0] srcB,
  input wire faultOnQuiet,
  input wire vectorMode,
  input wire invalidMask,
  input wire invalidStickyIn,
  input wire [31:0] coreResult,
  input wire [8:0] coreExp,
  input wire coreInvalid,
  output reg resValid_ff,
  output reg [31:0] result_ff,
  output reg destWrite_ff,
  output reg invalidRaise_ff,
  output reg invalidSticky_ff,
  output reg overflow_ff,
  output reg [1:0] cmpResult_ff,
  output reg [2:0] classA_ff,
  output reg [2:0] classB_ff
);

  function [2:0] classify;
    input [31:0] v;
    begin
      if (v[`FPNP_EXP_HI:`FPNP_EXP_LO] == `FPNP_EXP_MAX) begin
        if (v[`FPNP_FRAC_HI:`FPNP_FRAC_LO] == 23'h000000)
          classify = `FPNP_CL_INF;
        else if (v[`FPNP_QUIET_BIT])
          classify = `FPNP_CL_QUIET_NOT_A_NUMBER;
        else
          classify = `FPNP_CL_SIGNALING_NOT_A_NUMBER;
      end else if (v[`FPNP_EXP_HI:`FPNP_EXP_LO] == `FPNP_EXP_ZERO) begin
        if (v[`FPNP_FRAC_HI:`FPNP_FRAC_LO] == 23'h000000)
          classify = `FPNP_CL_ZERO;
        else
          classify = `FPNP_CL_DENORM;
      end else begin
        classify = `FPNP_CL_NORM;
      end
    end
  endfunction

  function [31:0] quieten;
    input [31:0] v;
    begin
      quieten = v;
      quieten[`FPNP_QUIET_BIT] = 1'b1;
    end
  endfunction

  function isNan;
    input [2:0] c;
    begin
      isNan = (c == `FPNP_CL_QUIET_NOT_A_NUMBER) || (c == `FPNP_CL_SIGNALING_NOT_A_NUMBER);
    end
  endfunction

  // stage 1: classify and register operands
  reg s1Valid_ff;
  reg [2:0] s1Op_ff;
  reg [31:0] s1A_ff;
  reg [31:0] s1B_ff;
  reg [2:0] s1ClA_ff;
  reg [2:0] s1ClB_ff;
  reg s1Fq_ff;
  reg s1Vec_ff;
  reg s1Mask_ff;
  reg [31:0] s1Core_ff;
  reg [8:0] s1CoreExp_ff;
  reg s1CoreInv_ff;

  always @(posedge clk) begin
    if (rst) begin
      s1Valid_ff <= 1'b0;
      s1Op_ff <= 3'h0;
      s1A_ff <= 32'h00000000;
      s1B_ff <= 32'h00000000;
      s1ClA_ff <= 3'h0;
      s1ClB_ff <= 3'h0;
      s1Fq_ff <= 1'b0;
      s1Vec_ff <= 1'b0;
      s1Mask_ff <= 1'b1;
      s1Core_ff <= 32'h00000000;
      s1CoreExp_ff <= 9'h000;
      s1CoreInv_ff <= 1'b0;
    end else begin
      s1Valid_ff <= reqValid;
      s1Op_ff <= reqOp;
      s1A_ff <= srcA;
      s1B_ff <= srcB;
      s1ClA_ff <= classify(srcA);
      s1ClB_ff <= classify(srcB);
      s1Fq_ff <= faultOnQuiet;
      s1Vec_ff <= vectorMode;
      s1Mask_ff <= invalidMask;
      s1Core_ff <= coreResult;
      s1CoreExp_ff <= coreExp;
      s1CoreInv_ff <= coreInvalid;
    end
  end

  // stage 2: select result
  wire unary = (s1Op_ff == `FPNP_OP_UNARY);
  wire isCmp = (s1Op_ff == `FPNP_OP_CMP) || (s1Op_ff == `FPNP_OP_CMPS);
  wire fq = s1Fq_ff || (s1Op_ff == `FPNP_OP_CMPS);
  wire nanA = isNan(s1ClA_ff);
  wire nanB = !unary && isNan(s1ClB_ff);
  wire snA = (s1ClA_ff == `FPNP_CL_SIGNALING_NOT_A_NUMBER);
  wire snB = !unary && (s1ClB_ff == `FPNP_CL_SIGNALING_NOT_A_NUMBER);
  wire qnA = (s1ClA_ff == `FPNP_CL_QUIET_NOT_A_NUMBER);
  wire qnB = !unary && (s1ClB_ff == `FPNP_CL_QUIET_NOT_A_NUMBER);
  wire infA = (s1ClA_ff == `FPNP_CL_INF);
  wire infB = (s1ClB_ff == `FPNP_CL_INF);
  wire zA = (s1ClA_ff == `FPNP_CL_ZERO);
  wire zB = (s1ClB_ff == `FPNP_CL_ZERO);
  // operand-based invalid cases on infinities
  wire infInvalid = ((s1Op_ff == `FPNP_OP_ADD) && infA && infB &&
                     (s1A_ff[31] != s1B_ff[31])) ||
                    ((s1Op_ff == `FPNP_OP_SUB) && infA && infB &&
                     (s1A_ff[31] == s1B_ff[31])) ||
                    ((s1Op_ff == `FPNP_OP_MUL) &&
                     ((infA && zB) || (zA && infB)));
  wire nanInvalid = snA || snB || (fq && (qnA || qnB));
  wire anyInvalid = nanInvalid || infInvalid || s1CoreInv_ff;
  wire aLarger = (s1A_ff[22:0] >= s1B_ff[22:0]);

  reg [31:0] nxt_result;
  reg [1:0] nxt_cmp;
  reg [31:0] magA;
  reg [31:0] magB;
  always @* begin
    magA = 32'h00000000;
    magB = 32'h00000000;
    nxt_result = s1Core_ff;
    if (nanA && nanB) begin
      if (s1Vec_ff)
        nxt_result = quieten(s1A_ff);
      else if (snA && qnB)
        nxt_result = s1B_ff;
      else if (qnA && snB)
        nxt_result = s1A_ff;
      else if (aLarger)
        nxt_result = quieten(s1A_ff);
      else
        nxt_result = quieten(s1B_ff);
    end else if (nanA) begin
      nxt_result = quieten(s1A_ff);
    end else if (nanB) begin
      nxt_result = quieten(s1B_ff);
    end else if (infInvalid || s1CoreInv_ff) begin
      nxt_result = INDEF_VALUE;
    end else if (s1CoreExp_ff > {1'b0, `FPNP_EXP_MAX} - 9'h001) begin
      nxt_result = {s1Core_ff[31], `FPNP_EXP_MAX, 23'h000000};
    end
    // affine ordering; sign-magnitude mapped to ordered key
    magA = s1A_ff[31] ? ~s1A_ff : {1'b1, s1A_ff[30:0]};
    magB = s1B_ff[31] ? ~s1B_ff : {1'b1, s1B_ff[30:0]};
    if (nanA || nanB)
      nxt_cmp = `FPNP_CMP_UN;
    else if ((zA && zB) || (magA == magB))
      nxt_cmp = `FPNP_CMP_EQ;
    else if (magA < magB)
      nxt_cmp = `FPNP_CMP_LT;
    else
      nxt_cmp = `FPNP_CMP_GT;
  end

  always @(posedge clk) begin
    if (rst) begin
      resValid_ff <= 1'b0;
      result_ff <= 32'h00000000;
      destWrite_ff <= 1'b0;
      invalidRaise_ff <= 1'b0;
      invalidSticky_ff <= 1'b0;
      overflow_ff <= 1'b0;
      cmpResult_ff <= `FPNP_CMP_EQ;
      classA_ff <= 3'h0;
      classB_ff <= 3'h0;
    end else begin
      resValid_ff <= s1Valid_ff;
      result_ff <= nxt_result;
      classA_ff <= s1ClA_ff;
      classB_ff <= s1ClB_ff;
      cmpResult_ff <= nxt_cmp;
      overflow_ff <= s1Valid_ff && !nanA && !nanB && !isCmp &&
                     (s1CoreExp_ff >= {1'b0, `FPNP_EXP_MAX});
      // unmasked invalid suppresses the write
      destWrite_ff <= s1Valid_ff && !(anyInvalid && !s1Mask_ff);
      invalidRaise_ff <= s1Valid_ff && anyInvalid && !s1Mask_ff;
      // sticky is an or onto the incoming flag, so a set is never lost
      invalidSticky_ff <= invalidStickyIn ||
                          (s1Valid_ff && anyInvalid && s1Mask_ff);
    end
  end

endmodule

//--- fpnp_special_chk.sv
`timescale 1ns/1ps
`include "fpnp_map.vh"
module fpnp_special_chk (
  input wire clk,
  input wire rst,
  input wire reqValid,
  input wire [2:0] reqOp,
  input wire [31:0] srcA,
  input wire [31:0] srcB,
  input wire faultOnQuiet,
  input wire invalidMask,
  input wire coreInvalid,
  input wire resValid_ff,
  input wire [31:0] result_ff,
  input wire destWrite_ff,
  input wire invalidRaise_ff,
  input wire invalidSticky_ff,
  input wire [2:0] classA_ff,
  input wire [2:0] classB_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  function automatic bit nan(input [31:0] v);
    return v[30:23] == 8'hff && v[22:0] != 23'h0;
  endfunction
  sequence s_sigA; reqValid && nan(srcA) && !srcA[22]; endsequence
  sequence s_trap; ##2 invalidRaise_ff && !destWrite_ff; endsequence
  property p_lat; reqValid |-> ##2 resValid_ff; endproperty
  a_lat: assert property (p_lat) else $error("late result");
  property p_sig; s_sigA ##0 !invalidMask |-> s_trap; endproperty
  a_sig: assert property (p_sig) else $error("no trap");
  property p_qf; reqValid && faultOnQuiet && !invalidMask && nan(srcA)
    |-> s_trap; endproperty
  a_qf: assert property (p_qf) else $error("no quiet trap");
  property p_quiet; s_sigA ##0 invalidMask && reqOp == 3'h4
    |-> ##2 result_ff == ($past(srcA, 2) | 32'h00400000); endproperty
  a_quiet: assert property (p_quiet) else $error("not quieted");
  property p_sticky; s_sigA ##0 invalidMask
    |-> ##2 invalidSticky_ff && destWrite_ff; endproperty
  a_sticky: assert property (p_sticky) else $error("no flag");
  property p_inf; reqValid && srcA[30:0] == 31'h7f800000
    |-> ##2 classA_ff == 3'h3; endproperty
  a_inf: assert property (p_inf) else $error("bad class");
  property p_qcls; reqValid && nan(srcB) && srcB[22]
    |-> ##2 classB_ff == 3'h4; endproperty
  a_qcls: assert property (p_qcls) else $error("bad class");
  property p_indef; reqValid && coreInvalid && invalidMask && !nan(srcA)
    && !nan(srcB) |-> ##2 result_ff == `FPNP_INDEF_DEFAULT; endproperty
  a_indef: assert property (p_indef) else $error("no indef");
endmodule
bind fpnp_special_unit fpnp_special_chk fpnp_special_chk_inst (.*);

//--- fpnp_pipe_model.sv
`timescale 1ns/1ps
module fpnp_pipe_model (
  input wire clk,
  output reg [81:0] req
);
  initial req = 82'h0;
  // one issue slot per call; slow issuers just call less often
  task issue(input [2:0] o, input [31:0] a, input [31:0] b,
    input [4:0] f, input [8:0] e);
    @(posedge clk);
    req <= {1'b1, o, a, b, f, e};
    @(posedge clk);
    req[81] <= 1'b0;
    // sampled at edge n+1, answer stands after edge n+2
    @(posedge clk);
    #1;
  endtask
endmodule

//--- fpnp_special_unit_tb_top.sv
`timescale 1ns/1ps
`include "fpnp_map.vh"
module fpnp_special_unit_tb_top;
  localparam [31:0] SA = 32'h7f812345, QSA = 32'h7fc12345;
  localparam [31:0] SB = 32'h7f8abcde, QSB = 32'h7fcabcde;
  localparam [31:0] QA = 32'h7fc00010, QB = 32'h7fd00000;
  localparam [31:0] ONE = 32'h3f800000;
  localparam [8:0] N = 9'h080;
  reg clk = 1'b0;
  reg rst = 1'b1;
  integer n_mismatch = 0;
  integer checks_done = 0;
  wire reqValid, faultOnQuiet, vectorMode, invalidMask, invalidStickyIn;
  wire coreInvalid, resValid_ff, destWrite_ff, invalidRaise_ff;
  wire invalidSticky_ff, overflow_ff;
  wire [2:0] reqOp, classA_ff, classB_ff;
  wire [31:0] srcA, srcB, coreResult, result_ff;
  wire [8:0] coreExp;
  wire [1:0] cmpResult_ff;
  wire [81:0] req;
  assign {reqValid, reqOp, srcA, srcB, vectorMode, invalidMask, faultOnQuiet,
    coreInvalid, invalidStickyIn, coreExp} = req;
  // core datapath stands still; only special-case selection is under test
  assign coreResult = ONE;
  fpnp_pipe_model fpnp_pipe_model_inst (.*);
  fpnp_special_unit fpnp_special_unit_inst (.*);
  initial begin
    forever #25 clk = ~clk;
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // c is {write, raise, sticky}; 3'b111 means flags are not judged
  task run(input [2:0] o, input [31:0] a, input [31:0] b, input [4:0] f,
    input [8:0] x, input [31:0] e, input [2:0] c);
    fpnp_pipe_model_inst.issue(o, a, b, f, x);
    chk("valid", 32'h1, {31'h0, resValid_ff});
    if (c != 3'b111) begin
      if (c[2]) chk("result", e, result_ff);
      chk("flags", {29'h0, c},
        {29'h0, destWrite_ff, invalidRaise_ff, invalidSticky_ff});
    end
  endtask
  task t_conv;
    run(3'h0, SA, QB, 5'b01000, N, QB, 3'b101);
    run(3'h0, SA, QB, 5'b11000, N, QSA, 3'b101);
    run(3'h0, SA, SB, 5'b01000, N, QSB, 3'b101);
    run(3'h0, SA, SB, 5'b11000, N, QSA, 3'b101);
    run(3'h0, QA, QB, 5'b01000, N, QB, 3'b100);
    run(3'h0, QA, QB, 5'b11000, N, QA, 3'b100);
  endtask
  task t_single;
    run(3'h2, SA, ONE, 5'b01000, N, QSA, 3'b101);
    run(3'h1, ONE, QB, 5'b11000, N, QB, 3'b100);
    run(3'h4, SA, ONE, 5'b01000, N, QSA, 3'b101);
    run(3'h4, QA, ONE, 5'b01000, N, QA, 3'b100);
  endtask
  task t_trap;
    run(3'h0, 32'hff812345, ONE, 5'b00001, N, 0, 3'b011);
    chk("classA", 32'h5, {29'h0, classA_ff});
    run(3'h0, QA, ONE, 5'b00100, N, 0, 3'b010);
    run(3'h0, QA, ONE, 5'b01100, N, QA, 3'b101);
    run(3'h0, ONE, ONE, 5'b01010, N, `FPNP_INDEF_DEFAULT, 3'b101);
  endtask
  task t_inf;
    run(3'h0, ONE, ONE, 5'b01000, 9'h0ff, 32'h7f800000, 3'b100);
    chk("overflow", 32'h1, {31'h0, overflow_ff});
    run(3'h0, 32'h7f800000, 32'hff800000, 5'b01000, N,
      `FPNP_INDEF_DEFAULT, 3'b101);
    chk("overflow", 32'h0, {31'h0, overflow_ff});
    run(3'h3, 32'hff800000, 32'h00000001, 5'b01000, N, 0, 3'b111);
    chk("order", 32'h0, {30'h0, cmpResult_ff});
    chk("classA", 32'h3, {29'h0, classA_ff});
    chk("classB", 32'h1, {29'h0, classB_ff});
    run(3'h3, 32'h7f800000, 32'h7f7fffff, 5'b01000, N, 0, 3'b111);
    chk("order", 32'h2, {30'h0, cmpResult_ff});
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_conv;
    t_single;
    t_trap;
    t_inf;
    conclude;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
endmodule
